/* design/pfc_pkg.sv */
package pfc_pkg;

	// ----------------------------------------------------------------
	// Widths and depths
	// ----------------------------------------------------------------
	localparam int PC_W       = 13;
	localparam int SP_W       = 3;
	localparam int STK_DEPTH  = 8;
	localparam int DEPTH_W    = 4;
	localparam int EVT_W      = 2;

	// ----------------------------------------------------------------
	// Register byte offsets on the APB slave
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_PC_READBACK_LOW  = 8'h00;
	localparam logic [7:0] OFS_PC_READBACK_HIGH = 8'h04;
	localparam logic [7:0] OFS_STACK_PTR_STATUS = 8'h08;
	localparam logic [7:0] OFS_PC_LOW_BYTE      = 8'h0c;
	localparam logic [7:0] OFS_IRQ_STATUS       = 8'h10;
	localparam logic [7:0] OFS_IRQ_MASK         = 8'h14;

	// ----------------------------------------------------------------
	// Field positions, masks and reset values
	// ----------------------------------------------------------------
	localparam int         STK_OVF_BIT   = 7;
	localparam int         EVT_OVF_BIT   = 0;
	localparam int         EVT_HOLD_BIT  = 1;
	localparam logic [7:0] HI_MASK_SMALL = 8'h0f;
	localparam logic [7:0] HI_MASK_LARGE = 8'h1f;
	localparam logic [PC_W-1:0] PC_RESET = 13'h0000;
	localparam logic [PC_W-1:0] PC_MASK_SMALL = 13'h0fff;
	localparam logic [7:0]  BYTE_RESET  = 8'h00;
	localparam logic [SP_W-1:0] SP_RESET = 3'h0;
	localparam logic [DEPTH_W-1:0] DEPTH_FULL = 4'h8;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {PH_T1, PH_T2, PH_T3, PH_T4} pfc_phase_t;
	typedef enum logic [2:0] {K_NONE, K_ALU, K_JUMP, K_CALL, K_RET, K_INTERRUPT_RETURN_OP, K_SKZ, K_SKNZ}
		pfc_kind_t;
	typedef enum logic [3:0] {A_ADD, A_ADC, A_SUB, A_SBC, A_AND, A_OR, A_XOR, A_CPL,
		A_RR, A_RRC, A_RL, A_RLC, A_INC, A_DEC, A_PASS} pfc_alu_op_t;

	typedef struct packed {
		pfc_kind_t         kind;
		pfc_alu_op_t       alu_op;
		logic [7:0]        a;
		logic [7:0]        b;
		logic [PC_W-1:0]   target;
	} pfc_cmd_t;

	typedef struct packed {
		logic [7:0] res;
		logic       ov;
		logic       z;
		logic       c;
	} pfc_alu_t;

endpackage : pfc_pkg

/* design/pfc_core.sv */
// The implementer's own choices: the APB interface to the registers and the placing of the registers.
module pfc_core
	import pfc_pkg::*;
#(
	parameter bit              LARGE_PC   = 1'b1,
	parameter logic [PC_W-1:0] IRQ_VECTOR = 13'h0004
) (
	input  wire logic            pclk,
	input  wire logic            presetn,
	input  wire logic            psel,
	input  wire logic            penable,
	input  wire logic            pwrite,
	input  wire logic [7:0]      paddr,
	input  wire logic [31:0]     pwdata,
	output logic      [31:0]     prdata,
	output logic                 pready,
	output logic                 pslverr,
	input  wire pfc_cmd_t        cmd,
	input  wire logic            irq_req,
	output logic      [3:0]      instruction_phase_clocks,
	output logic      [PC_W-1:0] fetch_addr,
	output logic                 fetch_stb,
	output logic      [PC_W-1:0] exec_addr,
	output logic                 dummy_cycle,
	output logic                 irq_ack,
	output logic      [7:0]      alu_res,
	output logic                 alu_valid,
	output logic      [2:0]      status_flags,
	output logic                 irq
);

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic [PC_W-1:0] pc_fit(input logic [PC_W-1:0] v);
		pc_fit = LARGE_PC ? v : (v & PC_MASK_SMALL);
	endfunction : pc_fit

	function automatic pfc_alu_t alu_calc(input pfc_alu_op_t op, input logic [7:0] a,
		input logic [7:0] b, input logic cin);
		logic [8:0] s;
		pfc_alu_t   r;
		s = 9'h000;
		r = '0;
		unique case (op)
			A_ADD:  s = {1'b0, a} + {1'b0, b};
			A_ADC:  s = {1'b0, a} + {1'b0, b} + {8'h00, cin};
			A_SUB:  s = {1'b0, a} + {1'b0, ~b} + 9'h001;
			A_SBC:  s = {1'b0, a} + {1'b0, ~b} + {8'h00, cin};
			A_AND:  s = {1'b0, a & b};
			A_OR:   s = {1'b0, a | b};
			A_XOR:  s = {1'b0, a ^ b};
			A_CPL:  s = {1'b0, ~a};
			A_RR:   s = {1'b0, a[0], a[7:1]};
			A_RRC:  s = {a[0], cin, a[7:1]};
			A_RL:   s = {1'b0, a[6:0], a[7]};
			A_RLC:  s = {a[7], a[6:0], cin};
			A_INC:  s = {1'b0, a + 8'h01};
			A_DEC:  s = {1'b0, a - 8'h01};
			A_PASS: s = {1'b0, a};
			// Unused operation code yields zero
			default: s = 9'h000;
		endcase
		r.res = s[7:0];
		r.z   = (s[7:0] == 8'h00);
		r.c   = (op inside {A_ADD, A_ADC, A_SUB, A_SBC, A_RRC, A_RLC}) ? s[8] : cin;
		r.ov  = (op inside {A_ADD, A_ADC}) ? ((a[7] == b[7]) && (s[7] != a[7])) :
			(op inside {A_SUB, A_SBC}) ? ((a[7] != b[7]) && (s[7] != a[7])) : 1'b0;
		alu_calc = r;
	endfunction : alu_calc

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	pfc_phase_t      phase_reg;
	logic [PC_W-1:0] pc_reg, fetch_addr_reg, exec_addr_reg;
	logic            dummy_reg, fetch_stb_reg, irq_ack_reg, alu_valid_reg;
	logic [PC_W-1:0] stack_mem [STK_DEPTH];
	logic [SP_W-1:0] sp_reg;
	logic [DEPTH_W-1:0] depth_reg;
	logic            ovf_reg, pcl_pend_reg, irq_pend_reg;
	logic [7:0]      pcl_data_reg, hi_buf_reg, snap_hi_reg, alu_res_reg;
	logic [2:0]      status_reg;
	logic [EVT_W-1:0] irq_stat_reg, irq_mask_reg;
	logic            irq_reg, pready_reg, pslverr_reg;
	logic [31:0]     prdata_reg;
	logic            req_s1_reg, req_s2_reg, req_s3_reg;
	logic [3:0]      phase_oh_reg;

	// Decision for the current instruction slot
	logic            exec_now, redirect, do_push, do_pop, take_irq, alu_now;
	logic [PC_W-1:0] npc;
	logic [SP_W-1:0] sp_dec;
	logic            stk_full, stk_empty;
	pfc_alu_t        alu_out;
	logic [7:0]      exec_hi;

	assign exec_now  = (phase_reg == PH_T4);
	assign sp_dec    = SP_W'(sp_reg - 3'h1);
	assign stk_full  = (depth_reg == DEPTH_FULL);
	assign stk_empty = (depth_reg == '0);
	assign alu_out   = alu_calc(cmd.alu_op, cmd.a, cmd.b, status_reg[0]);
	assign exec_hi   = 8'(exec_addr_reg >> 8) & (LARGE_PC ? HI_MASK_LARGE : HI_MASK_SMALL);

	// ----------------------------------------------------------------
	// Sequencer: four phases per instruction cycle
	// ----------------------------------------------------------------
	// phase divider
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			phase_reg    <= PH_T1;
			phase_oh_reg <= 4'h1;
		end else begin
			unique case (phase_reg)
				PH_T1: phase_reg <= PH_T2;
				PH_T2: phase_reg <= PH_T3;
				PH_T3: phase_reg <= PH_T4;
				PH_T4: phase_reg <= PH_T1;
			endcase
			phase_oh_reg <= {phase_oh_reg[2:0], phase_oh_reg[3]};
		end
	end

	// Resolve what the slot does at the end of its last phase
	always_comb begin
		npc      = pc_reg;
		redirect = 1'b0;
		do_push  = 1'b0;
		do_pop   = 1'b0;
		take_irq = 1'b0;
		alu_now  = 1'b0;
		if (pcl_pend_reg) begin
			npc      = {exec_addr_reg[PC_W-1:8], pcl_data_reg};
			redirect = 1'b1;
		end else if (!dummy_reg) begin
			unique case (cmd.kind)
				K_NONE: ;
				K_ALU:  alu_now = 1'b1;
				K_JUMP: begin
					npc      = cmd.target;
					redirect = 1'b1;
				end
				K_CALL: begin
					npc      = cmd.target;
					redirect = 1'b1;
					do_push  = 1'b1;
				end
				K_RET, K_INTERRUPT_RETURN_OP: begin
					npc      = stack_mem[sp_dec];
					redirect = 1'b1;
					do_pop   = 1'b1;
				end
				K_SKZ: begin
					alu_now  = 1'b1;
					redirect = alu_out.z;
				end
				K_SKNZ: begin
					alu_now  = 1'b1;
					redirect = !alu_out.z;
				end
			endcase
			if (irq_pend_reg && !stk_full && (cmd.kind inside {K_NONE, K_ALU})) begin
				take_irq = 1'b1;
				do_push  = 1'b1;
				npc      = IRQ_VECTOR;
				redirect = 1'b1;
			end
		end
		npc = pc_fit(npc);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pc_reg         <= PC_RESET;
			fetch_addr_reg <= PC_RESET;
			exec_addr_reg  <= PC_RESET;
			dummy_reg      <= 1'b1;
			fetch_stb_reg  <= 1'b0;
		end else begin
			fetch_stb_reg <= exec_now;
			if (exec_now) begin
				fetch_addr_reg <= npc;
				pc_reg         <= pc_fit(PC_W'(npc + 13'h0001));
				exec_addr_reg  <= fetch_addr_reg;
				dummy_reg      <= redirect;
			end
		end
	end

	// ----------------------------------------------------------------
	// Hardware return stack
	// ----------------------------------------------------------------
	// push and pop of return addresses
	always_ff @(posedge pclk) begin
		if (exec_now && do_push) begin
			stack_mem[sp_reg] <= fetch_addr_reg;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sp_reg    <= SP_RESET;
			depth_reg <= '0;
		end else if (exec_now && do_push) begin
			sp_reg    <= SP_W'(sp_reg + 3'h1);
			depth_reg <= stk_full ? depth_reg : DEPTH_W'(depth_reg + 4'h1);
		end else if (exec_now && do_pop) begin
			sp_reg    <= sp_dec;
			depth_reg <= stk_empty ? depth_reg : DEPTH_W'(depth_reg - 4'h1);
		end
	end

	// Overflow and interrupt hold-off events
	logic ovf_evt, hold_evt;
	assign ovf_evt  = exec_now && ((do_push && !take_irq && stk_full) ||
		(do_pop && stk_empty));
	assign hold_evt = exec_now && irq_pend_reg && stk_full && !dummy_reg;

	// Bus strobes
	logic apb_setup, apb_done, wr_done, rd_done;
	assign apb_setup = psel && !penable;
	assign apb_done  = psel && penable && pready_reg;
	assign wr_done   = apb_done && pwrite;
	assign rd_done   = apb_done && !pwrite;

	// flag set; only software clears, set wins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ovf_reg <= 1'b0;
		end else if (ovf_evt) begin
			ovf_reg <= 1'b1;
		end else if (wr_done && paddr == OFS_STACK_PTR_STATUS && !pwdata[STK_OVF_BIT]) begin
			ovf_reg <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Interrupt request path
	// ----------------------------------------------------------------
	// Two-stage synchroniser, then rising edge detect on stage two
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			req_s1_reg <= 1'b0;
			req_s2_reg <= 1'b0;
			req_s3_reg <= 1'b0;
		end else begin
			req_s1_reg <= irq_req;
			req_s2_reg <= req_s1_reg;
			req_s3_reg <= req_s2_reg;
		end
	end

	// request recorded even while held off
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_pend_reg <= 1'b0;
			irq_ack_reg  <= 1'b0;
		end else begin
			irq_ack_reg <= exec_now && take_irq;
			if (req_s2_reg && !req_s3_reg) begin
				irq_pend_reg <= 1'b1;
			end else if (exec_now && take_irq) begin
				irq_pend_reg <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// ALU and status
	// ----------------------------------------------------------------
	// result and flags update
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			alu_res_reg   <= BYTE_RESET;
			status_reg    <= 3'h0;
			alu_valid_reg <= 1'b0;
		end else begin
			alu_valid_reg <= exec_now && alu_now;
			if (exec_now && alu_now) begin
				alu_res_reg <= alu_out.res;
				status_reg  <= {alu_out.ov, alu_out.z, alu_out.c};
			end
		end
	end

	// ----------------------------------------------------------------
	// APB slave, one wait-free access phase
	// ----------------------------------------------------------------
	logic [31:0] rd_mux;
	logic        mapped;
	always_comb begin
		rd_mux = 32'h0000_0000;
		mapped = 1'b1;
		unique case (paddr)
			OFS_PC_READBACK_LOW:  rd_mux = {24'h000000, exec_addr_reg[7:0]};
			OFS_PC_READBACK_HIGH: rd_mux = {24'h000000, hi_buf_reg};
			OFS_STACK_PTR_STATUS: rd_mux = {24'h000000, ovf_reg, 4'h0, sp_reg};
			OFS_PC_LOW_BYTE:      rd_mux = {24'h000000, pc_reg[7:0]};
			OFS_IRQ_STATUS:       rd_mux = {30'h0, irq_stat_reg};
			OFS_IRQ_MASK:         rd_mux = {30'h0, irq_mask_reg};
			default:              mapped = 1'b0;
		endcase
	end

	// Handshake and read data launched in the setup cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_reg  <= 1'b0;
			pslverr_reg <= 1'b0;
			prdata_reg  <= 32'h0000_0000;
			snap_hi_reg <= BYTE_RESET;
		end else if (apb_setup) begin
			pready_reg  <= 1'b1;
			pslverr_reg <= !mapped;
			prdata_reg  <= pwrite ? 32'h0000_0000 : rd_mux;
			snap_hi_reg <= exec_hi;
		end else if (apb_done) begin
			pready_reg  <= 1'b0;
			pslverr_reg <= 1'b0;
		end
	end

	// low read loads buffer; held until next low read
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hi_buf_reg <= BYTE_RESET;
		end else if (rd_done && paddr == OFS_PC_READBACK_LOW) begin
			hi_buf_reg <= snap_hi_reg;
		end
	end

	// software write to the PC low byte queues a jump
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pcl_pend_reg <= 1'b0;
			pcl_data_reg <= BYTE_RESET;
		end else if (wr_done && paddr == OFS_PC_LOW_BYTE) begin
			pcl_pend_reg <= 1'b1;
			pcl_data_reg <= pwdata[7:0];
		end else if (exec_now) begin
			pcl_pend_reg <= 1'b0;
		end
	end

	// Sticky event status (write one clears, set wins), mask, level interrupt
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_stat_reg <= '0;
			irq_mask_reg <= '0;
			irq_reg      <= 1'b0;
		end else begin
			irq_stat_reg <= (irq_stat_reg &
				~((wr_done && paddr == OFS_IRQ_STATUS) ? pwdata[EVT_W-1:0] : 2'b00)) |
				{hold_evt, ovf_evt};
			if (wr_done && paddr == OFS_IRQ_MASK) begin
				irq_mask_reg <= pwdata[EVT_W-1:0];
			end
			irq_reg <= |(irq_stat_reg & irq_mask_reg);
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign prdata                   = prdata_reg;
	assign pready                   = pready_reg;
	assign pslverr                  = pslverr_reg;
	assign instruction_phase_clocks = phase_oh_reg;
	assign fetch_addr               = fetch_addr_reg;
	assign fetch_stb                = fetch_stb_reg;
	assign exec_addr                = exec_addr_reg;
	assign dummy_cycle              = dummy_reg;
	assign irq_ack                  = irq_ack_reg;
	assign alu_res                  = alu_res_reg;
	assign alu_valid                = alu_valid_reg;
	assign status_flags             = status_reg;
	assign irq                      = irq_reg;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_redirect;
		exec_now && redirect;
	endsequence

	sequence s_dummy_slot;
		dummy_reg [*4];
	endsequence

	chk_phase_order: assert property (phase_reg == PH_T4 |=> phase_reg == PH_T1)
		else $error("phase did not return to first phase");
	chk_pc_increment: assert property (fetch_stb |-> pc_reg == pc_fit(PC_W'(fetch_addr + 13'h0001)))
		else $error("pc not one past fetch address");
	chk_branch_dummy: assert property (s_redirect |=> s_dummy_slot)
		else $error("branch did not insert a dummy cycle");
	chk_skip_taken: assert property (exec_now && !dummy_reg && !pcl_pend_reg && cmd.kind == K_SKZ
		&& alu_out.z && !take_irq |=> dummy_reg && fetch_addr == $past(pc_reg))
		else $error("taken skip did not discard prefetch");
	chk_pcl_page: assert property (exec_now && pcl_pend_reg |=> dummy_reg &&
		fetch_addr[PC_W-1:8] == $past(exec_addr_reg[PC_W-1:8]))
		else $error("pc low write left the page");
	chk_hi_coherent: assert property (!(rd_done && paddr == OFS_PC_READBACK_LOW) |=>
		$stable(hi_buf_reg))
		else $error("high readback buffer changed without low read");
	chk_hi_zero: assert property (pready && !pwrite && paddr == OFS_PC_READBACK_HIGH |->
		prdata[7:5] == 3'b000)
		else $error("unused high readback bits not zero");
	chk_push_step: assert property (exec_now && do_push |=> sp_reg == SP_W'($past(sp_reg) + 3'h1))
		else $error("push did not step pointer");
	chk_ovf_set: assert property (exec_now && do_pop && stk_empty |=> ovf_reg && sp_reg == $past(sp_dec))
		else $error("empty return did not flag overflow");
	chk_ovf_sticky: assert property (ovf_reg && !(wr_done && paddr == OFS_STACK_PTR_STATUS) |=> ovf_reg)
		else $error("overflow flag dropped without software clear");
	chk_irq_hold: assert property (stk_full && irq_pend_reg |=> !irq_ack)
		else $error("interrupt acknowledged with full stack");
	chk_full_call: assert property (exec_now && cmd.kind == K_CALL && !dummy_reg && !pcl_pend_reg
		&& stk_full |=> ovf_reg)
		else $error("call with full stack did not flag overflow");

endmodule : pfc_core

/* testbench/program_flow_control_tb.sv */
module program_flow_control_tb
	import pfc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	// ----------------------------------------------------------------
	// Signals
	// ----------------------------------------------------------------
	localparam pfc_cmd_t IDLE = '{kind: K_NONE, alu_op: A_ADD, a: 8'h00, b: 8'h00, target: '0};
	logic            pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic            irq_req, fetch_stb, dummy_cycle, irq_ack, alu_valid, irq;
	logic [7:0]      paddr, alu_res;
	logic [31:0]     pwdata, prdata, rd;
	logic [3:0]      instruction_phase_clocks;
	logic [2:0]      status_flags;
	logic [PC_W-1:0] fetch_addr, exec_addr;
	pfc_cmd_t        cmd;
	int              n_errors, samples_checked, n_ack, cyc;

	pfc_core dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .cmd(cmd), .irq_req(irq_req),
		.instruction_phase_clocks(instruction_phase_clocks), .fetch_addr(fetch_addr),
		.fetch_stb(fetch_stb), .exec_addr(exec_addr), .dummy_cycle(dummy_cycle),
		.irq_ack(irq_ack), .alu_res(alu_res), .alu_valid(alu_valid),
		.status_flags(status_flags), .irq(irq));

	// Clock, acknowledge counter and hang guard
	always #4 pclk = ~pclk;
	always @(posedge pclk) begin
		if (irq_ack === 1'b1) n_ack++;
		cyc++;
		if (cyc == 20000) begin
			n_errors++;
			conclude();
		end
	end

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
		samples_checked++;
		if (g !== e) begin
			n_errors++;
			$display("CHECK FAILED at %0t: %s got %h expected %h", $time, m, g, e);
		end
	endtask : chk

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk) begin
			psel <= 1'b1;
			penable <= 1'b0;
			pwrite <= w;
			paddr <= a;
			pwdata <= d;
		end
		@(posedge pclk) penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rd = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 20) chk(32'h1, 32'h0, "apb no ready");
	endtask : apb

	task automatic wait_slot();
		int n;
		n = 0;
		do begin
			@(posedge pclk);
			#1;
			n++;
		end while (!(fetch_stb === 1'b1 && dummy_cycle === 1'b0) && n < 40);
		if (n >= 40) chk(32'h1, 32'h0, "no live slot");
	endtask : wait_slot

	// One instruction in the next live slot; cmd held over the sampling edge
	task automatic issue(input pfc_cmd_t c);
		wait_slot();
		@(posedge pclk) cmd <= c;
		repeat (2) @(posedge pclk);
		@(posedge pclk) cmd <= IDLE;
	endtask : issue

	task automatic run(input pfc_kind_t k, input logic [PC_W-1:0] t);
		issue('{kind: k, alu_op: A_PASS, a: 8'h00, b: 8'h00, target: t});
	endtask : run

	task automatic do_reset();
		@(posedge pclk) presetn <= 1'b0;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
	endtask : do_reset

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	// Reset values of readback and stack status
	task automatic t_reset_values();
		apb(1'b0, OFS_PC_READBACK_LOW, 32'h0);
		chk(rd, 32'h0, "low readback reset");
		apb(1'b0, OFS_PC_READBACK_HIGH, 32'h0);
		chk(rd, 32'h0, "high readback reset");
		apb(1'b0, OFS_STACK_PTR_STATUS, 32'h0);
		chk(rd, 32'h0, "stack status reset");
	endtask : t_reset_values

	// Eight calls fill the stack; interrupt held off; ninth call overflows
	task automatic t_calls();
		for (int i = 1; i <= 8; i++) begin
			run(K_CALL, 13'h0100 + 13'(i));
			apb(1'b0, OFS_STACK_PTR_STATUS, 32'h0);
			chk(rd, 32'(i % 8), "pointer after call");
		end
		@(posedge pclk) irq_req <= 1'b1;
		repeat (3) run(K_NONE, '0);
		chk(32'(n_ack), 32'h0, "ack withheld when full");
		apb(1'b0, OFS_IRQ_STATUS, 32'h0);
		chk(rd, 32'h2, "holdoff event");
		run(K_CALL, 13'h0200);
		apb(1'b0, OFS_STACK_PTR_STATUS, 32'h0);
		chk(rd, 32'h81, "ninth call overflow");
		run(K_RET, '0);
		apb(1'b0, OFS_STACK_PTR_STATUS, 32'h0);
		chk(rd, 32'h80, "flag sticky on return");
		repeat (2) run(K_NONE, '0);
		chk(32'(n_ack), 32'h1, "interrupt serviced after return");
		@(posedge pclk) irq_req <= 1'b0;
		apb(1'b1, OFS_STACK_PTR_STATUS, 32'h0);
		apb(1'b0, OFS_STACK_PTR_STATUS, 32'h0);
		chk(rd & 32'h80, 32'h0, "software clears flag");
	endtask : t_calls

	// Status, mask, level output and clear; unmapped access
	task automatic t_irq();
		apb(1'b0, OFS_IRQ_STATUS, 32'h0);
		chk(rd, 32'h3, "event bits");
		chk(32'(irq), 32'h0, "masked irq low");
		apb(1'b1, OFS_IRQ_MASK, 32'h1);
		repeat (2) @(posedge pclk);
		chk(32'(irq), 32'h1, "unmasked irq high");
		apb(1'b1, OFS_IRQ_STATUS, 32'h1);
		repeat (2) @(posedge pclk);
		chk(32'(irq), 32'h0, "irq low after clear");
		apb(1'b0, 8'h20, 32'h0);
		chk({31'h0, pslverr}, 32'h1, "unmapped error");
		chk(rd, 32'h0, "unmapped data");
	endtask : t_irq

	// Returns from an empty stack
	task automatic t_rets();
		for (int i = 1; i <= 8; i++) begin
			run(K_RET, '0);
			apb(1'b0, OFS_STACK_PTR_STATUS, 32'h0);
			chk(rd, 32'h80 | 32'((8 - i) % 8), "pointer after return");
		end
	endtask : t_rets

	// Jump with dummy slot, coherent two-byte readback, page jump by low byte
	task automatic t_jump_readback();
		run(K_JUMP, 13'h1123);
		#1;
		chk(32'(dummy_cycle), 32'h1, "dummy after jump");
		chk(32'(fetch_addr), 32'h1123, "fetch at target");
		wait_slot();
		chk(32'(exec_addr), 32'h1123, "executing target");
		apb(1'b0, OFS_PC_READBACK_LOW, 32'h0);
		chk(rd, 32'h23, "low readback");
		apb(1'b0, OFS_PC_READBACK_HIGH, 32'h0);
		chk(rd, 32'h11, "high readback");
		apb(1'b1, OFS_PC_READBACK_HIGH, 32'hff);
		apb(1'b0, OFS_PC_READBACK_HIGH, 32'h0);
		chk(rd, 32'h11, "buffer held, write ignored");
		apb(1'b1, OFS_PC_LOW_BYTE, 32'h45);
		wait_slot();
		chk(32'(exec_addr), 32'h1145, "page jump by low byte write");
		chk(32'(instruction_phase_clocks), 32'h1, "first phase at fetch");
		@(posedge pclk);
		#1;
		chk(32'(instruction_phase_clocks), 32'h2, "second phase");
	endtask : t_jump_readback

	// ALU results and flags, skips, return restore, read-only pointer
	task automatic t_alu_skip();
		logic [PC_W-1:0] f;
		issue('{kind: K_ALU, alu_op: A_ADD, a: 8'h7f, b: 8'h01, target: '0});
		#1;
		chk(32'(alu_valid), 32'h1, "alu result strobe");
		chk(32'(alu_res), 32'h80, "add result");
		chk(32'(status_flags), 32'h4, "signed overflow flag");
		issue('{kind: K_ALU, alu_op: A_ADD, a: 8'hff, b: 8'h01, target: '0});
		#1;
		chk(32'(alu_res), 32'h00, "add wraps");
		chk(32'(status_flags), 32'h3, "zero and carry flags");
		issue('{kind: K_ALU, alu_op: A_SUB, a: 8'h05, b: 8'h07, target: '0});
		#1;
		chk(32'(alu_res), 32'hfe, "subtract result");
		chk(32'(status_flags), 32'h0, "borrow clears carry");
		run(K_SKZ, '0);
		f = fetch_addr;
		#1;
		chk(32'(dummy_cycle), 32'h1, "taken skip dummy");
		chk(32'(fetch_addr), 32'(f) + 32'h1, "skip fetches next");
		run(K_SKNZ, '0);
		#1;
		chk(32'(dummy_cycle), 32'h0, "untaken skip no dummy");
		run(K_CALL, 13'h0a00);
		f = fetch_addr;
		run(K_INTERRUPT_RETURN_OP, '0);
		#1;
		chk(32'(fetch_addr), 32'(f), "return restores pushed pc");
		apb(1'b1, OFS_STACK_PTR_STATUS, 32'hff);
		apb(1'b0, OFS_STACK_PTR_STATUS, 32'h0);
		chk(rd, 32'h80, "pointer not writable, flag kept");
	endtask : t_alu_skip

	task automatic conclude();
		$display("checks %0d errors %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : conclude

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		pclk = 1'b0;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		cmd = IDLE;
		irq_req = 1'b0;
		n_errors = 0;
		samples_checked = 0;
		n_ack = 0;
		cyc = 0;
		do_reset();
		t_reset_values();
		t_calls();
		t_irq();
		do_reset();
		t_rets();
		t_jump_readback();
		t_alu_skip();
		conclude();
	end
endmodule : program_flow_control_tb
